// file: common/dlm_map.vh
// Constants for the load-strobe mask and reset control block
// Functional notes
// - Command 0101 loads mask from DB3 and DB0
// - Mask write ignores channel address bits
// - Mask bits reset to zero
// - Channel B mask DB3, channel A DB0
// - Masked channel ignores load strobe falling edge
// - 0001 writes input; DAC if strobe low
// - 0010 copies input register to DAC
// - 0011 writes input and DAC registers
// - Strobe falling edge loads unmasked DACs
// - Strobe held low ignores mask bits
// - Hardware reset clears to zero/midscale
// - Reset low blocks updates; held cleared
// - Command 0110 performs software reset
// - Power-on reset ignores strobe and reset
// - Power-up level follows reset-level select
// - Command code in DB23..DB20
// - Strobe low 0001 updates at frame end
`ifndef DLM_MAP_VH
`define DLM_MAP_VH
`define DLM_FRAME_BITS 24
`define DLM_CMD_HI 23
`define DLM_CMD_LO 20
`define DLM_ADDR_A 16
`define DLM_ADDR_B 19
`define DLM_DATA_HI 15
`define DLM_DATA_LO 0
`define DLM_MASK_B_BIT 3
`define DLM_MASK_A_BIT 0
`define DLM_CMD_WR_IN 4'h1
`define DLM_CMD_UPD 4'h2
`define DLM_CMD_WR_UPD 4'h3
`define DLM_CMD_MASK 4'h5
`define DLM_CMD_SWRST 4'h6
`define DLM_MASK_RESET 2'h0
`define DLM_ZERO_CODE 16'h0000
`define DLM_MID_CODE 16'h8000
`define DLM_POR_CYCLES 8'h20
`endif

// file: core/dlm_ctrl.v
// Load-strobe mask, update and reset control of a dual-channel DAC
`timescale 1ns/1ps
`include "dlm_map.vh"
module dlm_ctrl #(
  parameter DATA_W = 16,
  parameter POR_CYCLES = `DLM_POR_CYCLES
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_sclk,
  input wire i_frame_sel_n,
  input wire i_sdin,
  input wire i_load_strobe_pin_n,
  input wire i_hw_reset_n,
  input wire i_reset_level_select,
  output reg [DATA_W-1:0] o_dac_a,
  output reg [DATA_W-1:0] o_dac_b,
  output reg [DATA_W-1:0] o_input_a,
  output reg [DATA_W-1:0] o_input_b,
  output reg [1:0] o_load_strobe_mask,
  output reg o_por_busy
);
  // Pin order in the synchroniser bundle
  localparam P_SCLK = 0;
  localparam P_FRAME = 1;
  localparam P_LDS = 2;
  localparam P_RST = 3;
  localparam P_SEL = 4;
  localparam P_SDIN = 5;

  wire [5:0] pins_async;
  wire [5:0] pins_sync;
  wire [7:0] por_init;
  wire [`DLM_FRAME_BITS-1:0] word;
  wire word_valid;

  reg sclk_d_reg;
  reg frame_d_reg;
  reg lds_d_reg;
  reg [7:0] por_cnt_reg;
  reg [7:0] por_cnt_next;
  reg [DATA_W-1:0] dac_a_next;
  reg [DATA_W-1:0] dac_b_next;
  reg [DATA_W-1:0] in_a_next;
  reg [DATA_W-1:0] in_b_next;
  reg [1:0] mask_next;
  reg por_busy_next;

  wire sclk_rise;
  wire frame_rise;
  wire lds_fall;
  wire lds_low;
  wire rst_low;
  wire [3:0] cmd;
  wire sel_a;
  wire sel_b;
  wire [DATA_W-1:0] data;
  wire [DATA_W-1:0] clear_code;

  // Reset code chosen by the level select pin
  function [DATA_W-1:0] reset_code;
    input sel;
    begin
      if (sel) begin
        reset_code = `DLM_MID_CODE;
      end else begin
        reset_code = `DLM_ZERO_CODE;
      end
    end
  endfunction

  assign por_init = POR_CYCLES[7:0];
  // Data goes through the same two flops so it stays aligned with sclk
  assign pins_async = {i_sdin, i_reset_level_select, i_hw_reset_n,
                       i_load_strobe_pin_n, i_frame_sel_n, i_sclk};

  // Idle-high pins start high so no false edge appears after reset
  dlm_sync #(
    .WIDTH(6),
    .INIT(6'h0E)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  assign sclk_rise = pins_sync[P_SCLK] & ~sclk_d_reg;
  assign frame_rise = pins_sync[P_FRAME] & ~frame_d_reg;
  assign lds_fall = ~pins_sync[P_LDS] & lds_d_reg;
  assign lds_low = ~pins_sync[P_LDS];
  assign rst_low = ~pins_sync[P_RST];

  dlm_shift #(
    .BITS(`DLM_FRAME_BITS)
  ) u_shift (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sclk_rise(sclk_rise),
    .i_frame_low(~pins_sync[P_FRAME]),
    .i_frame_rise(frame_rise),
    .i_sdin(pins_sync[P_SDIN]),
    .o_word(word),
    .o_word_valid(word_valid)
  );

  assign cmd = word[`DLM_CMD_HI:`DLM_CMD_LO];
  assign sel_a = word[`DLM_ADDR_A];
  assign sel_b = word[`DLM_ADDR_B];
  assign data = word[`DLM_DATA_HI:`DLM_DATA_LO];
  assign clear_code = reset_code(pins_sync[P_SEL]);

  always @* begin
    dac_a_next = o_dac_a;
    dac_b_next = o_dac_b;
    in_a_next = o_input_a;
    in_b_next = o_input_b;
    mask_next = o_load_strobe_mask;
    por_cnt_next = por_cnt_reg;
    por_busy_next = o_por_busy;
    if (o_por_busy) begin
      // Strobe and hardware reset pins are not looked at here
      // Outputs track the select pin until power-up ends
      dac_a_next = clear_code;
      dac_b_next = clear_code;
      in_a_next = clear_code;
      in_b_next = clear_code;
      por_cnt_next = por_cnt_reg - 8'h01;
      if (por_cnt_reg == 8'h01) begin
        por_busy_next = 1'b0;
      end
    end else if (rst_low) begin
      // Held cleared and frozen while reset is low
      dac_a_next = clear_code;
      dac_b_next = clear_code;
      in_a_next = clear_code;
      in_b_next = clear_code;
    end else begin
      // Unmasked channels follow the strobe edge; a masked channel
      // sees the pin as high
      if (lds_fall && !o_load_strobe_mask[0]) begin
        dac_a_next = o_input_a;
      end
      if (lds_fall && !o_load_strobe_mask[1]) begin
        dac_b_next = o_input_b;
      end
      if (word_valid) begin
        case (cmd)
          `DLM_CMD_WR_IN: begin
            // Strobe held low updates the DAC too, mask ignored
            if (sel_a) begin
              in_a_next = data;
              if (lds_low) begin
                dac_a_next = data;
              end
            end
            if (sel_b) begin
              in_b_next = data;
              if (lds_low) begin
                dac_b_next = data;
              end
            end
          end
          `DLM_CMD_UPD: begin
            if (sel_a) begin
              dac_a_next = o_input_a;
            end
            if (sel_b) begin
              dac_b_next = o_input_b;
            end
          end
          `DLM_CMD_WR_UPD: begin
            if (sel_a) begin
              in_a_next = data;
              dac_a_next = data;
            end
            if (sel_b) begin
              in_b_next = data;
              dac_b_next = data;
            end
          end
          `DLM_CMD_MASK: begin
            // Address bits and DB2..DB1 play no part
            mask_next = {word[`DLM_MASK_B_BIT], word[`DLM_MASK_A_BIT]};
          end
          `DLM_CMD_SWRST: begin
            // Back to the power-on code and default mask
            dac_a_next = clear_code;
            dac_b_next = clear_code;
            in_a_next = clear_code;
            in_b_next = clear_code;
            mask_next = `DLM_MASK_RESET;
          end
          default: begin
            mask_next = o_load_strobe_mask;
          end
        endcase
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      sclk_d_reg <= 1'b0;
      frame_d_reg <= 1'b1;
      lds_d_reg <= 1'b1;
      por_cnt_reg <= por_init;
      o_por_busy <= 1'b1;
      o_dac_a <= `DLM_ZERO_CODE;
      o_dac_b <= `DLM_ZERO_CODE;
      o_input_a <= `DLM_ZERO_CODE;
      o_input_b <= `DLM_ZERO_CODE;
      o_load_strobe_mask <= `DLM_MASK_RESET;
    end else begin
      sclk_d_reg <= pins_sync[P_SCLK];
      frame_d_reg <= pins_sync[P_FRAME];
      lds_d_reg <= pins_sync[P_LDS];
      por_cnt_reg <= por_cnt_next;
      o_por_busy <= por_busy_next;
      o_dac_a <= dac_a_next;
      o_dac_b <= dac_b_next;
      o_input_a <= in_a_next;
      o_input_b <= in_b_next;
      o_load_strobe_mask <= mask_next;
    end
  end
endmodule

// file: core/dlm_shift.v
// Serial frame shifter: collects bits on link clock rising edges
`timescale 1ns/1ps
`include "dlm_map.vh"
module dlm_shift #(
  parameter BITS = `DLM_FRAME_BITS
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_sclk_rise,
  input wire i_frame_low,
  input wire i_frame_rise,
  input wire i_sdin,
  output reg [BITS-1:0] o_word,
  output reg o_word_valid
);
  reg [BITS-1:0] shift_reg;
  always @(posedge i_clk) begin
    if (i_srst) begin
      shift_reg <= {BITS{1'b0}};
      o_word <= {BITS{1'b0}};
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= 1'b0;
      if (i_frame_low && i_sclk_rise) begin
        shift_reg <= {shift_reg[BITS-2:0], i_sdin};
      end
      // Last 24 bits shifted in form the word
      if (i_frame_rise) begin
        o_word <= shift_reg;
        o_word_valid <= 1'b1;
      end
    end
  end
endmodule

// file: core/dlm_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module dlm_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_srst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= INIT;
      o_sync <= INIT;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// file: test/dlm_ctrl_properties.sv
// Port checks for the load-strobe mask and reset control
`timescale 1ns/1ps
module dlm_ctrl_chk #(
  parameter POR_CYCLES = 4
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_frame_sel_n,
  input wire i_load_strobe_pin_n,
  input wire i_hw_reset_n,
  input wire i_reset_level_select,
  input wire [15:0] o_dac_a,
  input wire [15:0] o_dac_b,
  input wire [15:0] o_input_a,
  input wire [15:0] o_input_b,
  input wire [1:0] o_load_strobe_mask,
  input wire o_por_busy
);
  logic [7:0] por_cnt;
  wire [15:0] clr = {i_reset_level_select, 15'h0};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Busy length is counted; select pin is assumed quiet during POR
  always @(posedge i_clk) begin
    if (i_srst)
      por_cnt <= 8'h0;
    else if (o_por_busy)
      por_cnt <= por_cnt + 8'h1;
  end
  AST_SRST: assert property (disable iff (1'b0)
    i_srst |=> o_load_strobe_mask == 2'h0 && o_por_busy) else $error("srst");
  AST_POR_LEN: assert property (
    $fell(o_por_busy) |-> por_cnt inside {[POR_CYCLES-1:POR_CYCLES+2]})
    else $error("por length");
  AST_POR_CODE: assert property (
    o_por_busy [*4] |-> o_dac_a == clr && o_dac_b == clr)
    else $error("por code");
  AST_HW_CLR: assert property (
    (!i_hw_reset_n && !o_por_busy) [*5] |-> o_dac_a == clr
    && o_dac_b == clr && o_input_a == clr) else $error("hw clear");
  AST_LOAD_A: assert property (
    $fell(i_load_strobe_pin_n) && !o_load_strobe_mask[0] && i_hw_reset_n
    && !o_por_busy |-> ##[2:8] o_dac_a == o_input_a) else $error("load a");
  AST_LOAD_B: assert property (
    $fell(i_load_strobe_pin_n) && !o_load_strobe_mask[1] && i_hw_reset_n
    && !o_por_busy |-> ##[2:8] o_dac_b == o_input_b) else $error("load b");
  AST_MASK_AT_END: assert property (
    $changed(o_load_strobe_mask) |-> i_frame_sel_n) else $error("mask");
  AST_IN_AT_END: assert property (
    $changed(o_input_a) || $changed(o_input_b) |-> i_frame_sel_n)
    else $error("input");
endmodule
bind dlm_ctrl dlm_ctrl_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_frame_sel_n(i_frame_sel_n),
  .i_load_strobe_pin_n(i_load_strobe_pin_n), .i_hw_reset_n(i_hw_reset_n),
  .i_reset_level_select(i_reset_level_select), .o_dac_a(o_dac_a),
  .o_dac_b(o_dac_b), .o_input_a(o_input_a), .o_input_b(o_input_b),
  .o_load_strobe_mask(o_load_strobe_mask), .o_por_busy(o_por_busy)
);

// file: test/dlm_ctrl_tb.sv
// Self-checking bench for the load-strobe mask and reset control
`timescale 1ns/1ps
module dlm_ctrl_tb;
  logic i_clk = 0, i_srst = 1, sb = 1, hr = 1, sel = 1;
  logic sclk, fs, sd, busy;
  logic [15:0] da, db, ia, ib;
  logic [1:0] msk;
  int error_cnt = 0, check_count = 0;
  always #2.5 i_clk = ~i_clk;
  dlm_host u_host (.o_sclk(sclk), .o_frame_sel_n(fs), .o_sdin(sd));
  dlm_ctrl #(.POR_CYCLES(4)) DUT (.i_clk(i_clk), .i_srst(i_srst),
    .i_sclk(sclk), .i_frame_sel_n(fs), .i_sdin(sd),
    .i_load_strobe_pin_n(sb), .i_hw_reset_n(hr),
    .i_reset_level_select(sel), .o_dac_a(da), .o_dac_b(db),
    .o_input_a(ia), .o_input_b(ib), .o_load_strobe_mask(msk),
    .o_por_busy(busy));
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task por_wait;
    for (int i = 0; i < 99 && busy; i++) @(posedge i_clk);
    if (busy) begin
      error_cnt++;
      results;
    end
    cyc(3);
  endtask
  // DB19 selects B, DB16 selects A, data sits in DB15..DB0
  task wr(input [23:0] w);
    u_host.send(w);
    cyc(12);
  endtask
  task pulse;
    sb <= 0;
    cyc(10);
    sb <= 1;
    cyc(10);
  endtask
  initial begin
    cyc(10);
    i_srst <= 0;
    por_wait;
    chk(da, 16'h8000);
    chk({14'h0, msk}, 16'h0);
    $display("power-up test done");
    wr(24'h111234);
    chk(ia, 16'h1234);
    chk(da, 16'h8000);
    wr(24'h210000);
    chk(da, 16'h1234);
    wr(24'h5F000E);
    chk({14'h0, msk}, 16'h2);
    $display("command test done");
    wr(24'h18A555);
    wr(24'h113333);
    pulse;
    chk(da, 16'h3333);
    chk(db, 16'h8000);
    wr(24'h38C0DE);
    chk(db, 16'hC0DE);
    sb <= 0;
    cyc(8);
    wr(24'h115A5A);
    chk(da, 16'h5A5A);
    wr(24'h188888);
    chk(db, 16'h8888);
    sb <= 1;
    $display("strobe test done");
    hr <= 0;
    cyc(10);
    chk(ib, 16'h8000);
    hr <= 1;
    cyc(10);
    chk(da, 16'h8000);
    wr(24'h317111);
    wr(24'h600000);
    chk(da, 16'h8000);
    chk({14'h0, msk}, 16'h0);
    wr(24'h181357);
    chk(db, 16'h8000);
    pulse;
    chk(db, 16'h1357);
    $display("reset test done");
    sel <= 0;
    i_srst <= 1;
    cyc(10);
    i_srst <= 0;
    por_wait;
    chk(db, 16'h0000);
    $display("select test done");
    results;
  end
endmodule

// file: test/dlm_host.sv
// Serial host model that frames 24-bit words
`timescale 1ns/1ps
module dlm_host (
  output logic o_sclk,
  output logic o_frame_sel_n,
  output logic o_sdin
);
  initial begin
    o_sclk = 0;
    o_frame_sel_n = 1;
    o_sdin = 0;
  end
  // Clock parks low between frames; released data flips so it is not reused
  task send(input [23:0] w);
    o_frame_sel_n = 0;
    for (int i = 23; i >= 0; i--) begin
      o_sdin = w[i];
      #80 o_sclk = 1;
      #80 o_sclk = 0;
    end
    #80 o_frame_sel_n = 1;
    o_sdin = ~o_sdin;
  endtask
endmodule
